/* File: pkg/svs_consts.vh */
// named constants of the supply voltage supervisor
`ifndef SVS_CONSTS_VH
`define SVS_CONSTS_VH

// clock and timing, times in ns
`define SVS_CLK_NS        10
`define SVS_DEG_NS        8000
`define SVS_IO_STG_NS     4000000
`define SVS_RAIL_STG_NS   3000000
`define SVS_CNT_W         20

// monitor channels, deglitched comparator inputs
`define SVS_NCH           15
`define SVS_CH_IO_OV      0
`define SVS_CH_IO_UV      1
`define SVS_CH_BAT_UV     2
`define SVS_CH_FB_OV      3
`define SVS_CH_FB_UV      6
`define SVS_CH_FB_DUV     9
`define SVS_CH_EXT_OV     11
`define SVS_CH_EXT_UV     13

// status and mask bit positions
`define SVS_NSTAT         23
`define SVS_ST_IO_OV      0
`define SVS_ST_IO_UV      1
`define SVS_ST_IO_STG     2
`define SVS_ST_BAT_UV     3
`define SVS_ST_FB_OV      4
`define SVS_ST_FB_UV      7
`define SVS_ST_FB_STG     10
`define SVS_ST_EXT_OV     13
`define SVS_ST_EXT_UV     15
`define SVS_ST_EXT_STG    17
`define SVS_ST_WARN_A     19
`define SVS_ST_WARN_B     20
`define SVS_ST_FLT_A      21
`define SVS_ST_FLT_B      22

// register byte offsets
`define SVS_ADR_STATUS    8'h00
`define SVS_ADR_MASK      8'h04
`define SVS_ADR_CTRL      8'h08
`define SVS_ADR_LIVE      8'h0C

// reset values
`define SVS_MASK_RST      23'h180000
`define SVS_CTRL_RST      2'h0
`define SVS_STAT_RST      23'h000000

`endif

/* File: logic/svs_mon.v */
// one deglitch and short-to-ground timer channel
`timescale 1ns/100ps
`include "svs_consts.vh"

module svs_mon #(
  parameter DEG_CYC = 800,
  parameter STG_CYC = 300000,
  parameter CW      = `SVS_CNT_W
) (
  input  wire          clk,     // system clock
  input  wire          reset,   // async reset, active high
  input  wire          enable,  // channel supervised
  input  wire          level,   // synchronised comparator level
  output reg           qual,    // level held past deglitch time
  output reg           deg_evt, // pulse when deglitch time elapses
  output reg           stg_evt  // pulse when stg time elapses
);

  // limits are worked out as integers, then cut to the counter width
  localparam integer  DEG_M1  = DEG_CYC - 1;
  localparam integer  STG_M1  = STG_CYC - 1;
  localparam [CW-1:0] DEG_LIM = DEG_M1[CW-1:0];
  localparam [CW-1:0] STG_LIM = STG_M1[CW-1:0];
  localparam [CW-1:0] ONE     = 1;

  reg [CW-1:0] deg_cnt_reg;
  reg [CW-1:0] stg_cnt_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      deg_cnt_reg <= {CW{1'b0}};
      stg_cnt_reg <= {CW{1'b0}};
      qual        <= 1'b0;
      deg_evt     <= 1'b0;
      stg_evt     <= 1'b0;
    end else if (!enable || !level) begin
      deg_cnt_reg <= {CW{1'b0}};
      stg_cnt_reg <= {CW{1'b0}};
      qual        <= 1'b0;
      deg_evt     <= 1'b0;
      stg_evt     <= 1'b0;
    end else begin
      if (deg_cnt_reg != DEG_LIM) begin
        deg_cnt_reg <= deg_cnt_reg + ONE;
      end
      deg_evt <= (deg_cnt_reg == DEG_LIM) && !qual;
      if (deg_cnt_reg == DEG_LIM) begin
        qual <= 1'b1;
      end
      if (stg_cnt_reg != STG_LIM) begin
        stg_cnt_reg <= stg_cnt_reg + ONE;
      end
      stg_evt <= (stg_cnt_reg == STG_LIM - ONE);
    end
  end

endmodule // svs_mon

/* File: logic/svs_top.v */
// supply voltage supervisor with wishbone register slave
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "svs_consts.vh"

// What this block does
// - io supply over or undervoltage event drives the reset output low
// - without a reset event the reset output is released high
// - monitor channel crossings shorter than the deglitch time are ignored, longer ones make events
// - io supply undervoltage past the stg time makes an io stg event
// - io stg event raises hard reset and sets the io stg flag
// - battery input undervoltage sets the readable battery flag
// - three converter feedbacks each have deglitched over and undervoltage events
// - converter and external undervoltage past stg time also make stg event
// - step-down deep undervoltage past the deglitch time makes an stg event
// - enabled rails are monitored, disabled rails are not
// - two external rails use window comparators with the same timing
// - external rail overvoltage or stg event drops that rail enable
// - reference warning raises interrupt and sets warn flag by cause
// - reference fault enters FAULT, shuts down, sets fault flag by cause
module svs_top #(
  parameter IO_STG_CYC   = (`SVS_IO_STG_NS + `SVS_CLK_NS - 1) / `SVS_CLK_NS,
  parameter RAIL_STG_CYC = (`SVS_RAIL_STG_NS + `SVS_CLK_NS - 1) / `SVS_CLK_NS,
  parameter DEG_CYC      = (`SVS_DEG_NS + `SVS_CLK_NS - 1) / `SVS_CLK_NS
) (
  input  wire        clk,           // 100 MHz system clock
  input  wire        reset,         // async reset, active high
  input  wire        wb_cyc_i,      // wishbone cycle
  input  wire        wb_stb_i,      // wishbone strobe
  input  wire        wb_we_i,       // wishbone write enable
  input  wire [7:0]  wb_adr_i,      // wishbone byte address
  input  wire [3:0]  wb_sel_i,      // wishbone byte selects
  input  wire [31:0] wb_dat_i,      // wishbone write data
  output reg  [31:0] wb_dat_o,      // wishbone read data
  output reg         wb_ack_o,      // wishbone acknowledge
  input  wire        io_ov_cmp,     // host_io_supply above ov threshold
  input  wire        io_uv_cmp,     // host_io_supply below uv threshold
  input  wire        bat_uv_cmp,    // battery_supply_input below uv
  input  wire [2:0]  fb_ov_cmp,     // feedback over: first, second, boost
  input  wire [2:0]  fb_uv_cmp,     // feedback under: first, second, boost
  input  wire [1:0]  fb_duv_cmp,    // step-down feedback deep under
  input  wire [1:0]  ext_ov_cmp,    // external rail a/b over
  input  wire [1:0]  ext_uv_cmp,    // external rail a/b under
  input  wire        ref_warn_cmp,  // reference difference above warning
  input  wire        ref_fault_cmp, // reference difference above fault
  input  wire        ref_cause_b,   // root cause: 0 selects a, 1 selects b
  input  wire [2:0]  rail_on,       // converter rails enabled by sequencer
  output reg         reset_out_n,   // reset output, active low
  output reg         hard_reset,    // hard reset request
  output reg         fault_req,     // FAULT state request, held
  output reg         ext_rail_a_en, // external rail a enable
  output reg         ext_rail_b_en, // external rail b enable
  output reg         irq            // interrupt, active high level
);

  localparam NCH = `SVS_NCH;
  localparam NST = `SVS_NSTAT;
  localparam NSY = NCH + 3;

  // byte-lane write mask, used by every writable register
  function [31:0] lane_mask;
    input [3:0] sel;
    begin
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // comparator inputs are asynchronous to clk
  wire [NSY-1:0] raw_in;
  reg  [NSY-1:0] sync1_reg;
  reg  [NSY-1:0] sync2_reg;

  assign raw_in = {ref_cause_b, ref_fault_cmp, ref_warn_cmp,
                   ext_uv_cmp, ext_ov_cmp, fb_duv_cmp,
                   fb_uv_cmp, fb_ov_cmp, bat_uv_cmp,
                   io_uv_cmp, io_ov_cmp};

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= {NSY{1'b0}};
      sync2_reg <= {NSY{1'b0}};
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire [NCH-1:0] ch_lvl = sync2_reg[NCH-1:0];
  wire           warn_s = sync2_reg[NCH];
  wire           flt_s  = sync2_reg[NCH+1];
  wire           cause_s = sync2_reg[NCH+2];

  reg  [1:0]     ext_en_reg;
  wire [NCH-1:0] ch_en;
  wire [NCH-1:0] ch_qual;
  wire [NCH-1:0] ch_deg;
  wire [NCH-1:0] ch_stg;

  assign ch_en[`SVS_CH_IO_OV]  = 1'b1;
  assign ch_en[`SVS_CH_IO_UV]  = 1'b1;
  assign ch_en[`SVS_CH_BAT_UV] = 1'b1;
  assign ch_en[`SVS_CH_FB_OV+2:`SVS_CH_FB_OV] = rail_on;
  assign ch_en[`SVS_CH_FB_UV+2:`SVS_CH_FB_UV] = rail_on;
  assign ch_en[`SVS_CH_FB_DUV+1:`SVS_CH_FB_DUV] = rail_on[1:0];
  assign ch_en[`SVS_CH_EXT_OV+1:`SVS_CH_EXT_OV] = ext_en_reg;
  assign ch_en[`SVS_CH_EXT_UV+1:`SVS_CH_EXT_UV] = ext_en_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      svs_mon #(
        .DEG_CYC (DEG_CYC),
        .STG_CYC ((gi == `SVS_CH_IO_UV) ? IO_STG_CYC : RAIL_STG_CYC),
        .CW      (`SVS_CNT_W)
      ) u_mon (
        .clk     (clk),
        .reset   (reset),
        .enable  (ch_en[gi]),
        .level   (ch_lvl[gi]),
        .qual    (ch_qual[gi]),
        .deg_evt (ch_deg[gi]),
        .stg_evt (ch_stg[gi])
      );
    end
  endgenerate

  // stg events per rail
  wire [2:0] fb_stg;
  wire [1:0] ext_stg;
  wire [1:0] ext_ov_evt;

  // stg from long uv or deep uv
  assign fb_stg = ch_stg[`SVS_CH_FB_UV+2:`SVS_CH_FB_UV] |
                  {1'b0, ch_deg[`SVS_CH_FB_DUV+1:`SVS_CH_FB_DUV]};
  assign ext_stg    = ch_stg[`SVS_CH_EXT_UV+1:`SVS_CH_EXT_UV];
  assign ext_ov_evt = ch_deg[`SVS_CH_EXT_OV+1:`SVS_CH_EXT_OV];

  // reference check edges
  reg warn_d_reg;
  reg flt_d_reg;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      warn_d_reg <= 1'b0;
      flt_d_reg  <= 1'b0;
    end else begin
      warn_d_reg <= warn_s;
      flt_d_reg  <= flt_s;
    end
  end
  wire warn_evt = warn_s && !warn_d_reg;
  wire flt_evt  = flt_s && !flt_d_reg;

  // event vector in status layout
  reg [NST-1:0] set_vec;
  always @* begin
    set_vec = {NST{1'b0}};
    set_vec[`SVS_ST_IO_OV]  = ch_deg[`SVS_CH_IO_OV];
    set_vec[`SVS_ST_IO_UV]  = ch_deg[`SVS_CH_IO_UV];
    set_vec[`SVS_ST_IO_STG] = ch_stg[`SVS_CH_IO_UV];
    set_vec[`SVS_ST_BAT_UV] = ch_deg[`SVS_CH_BAT_UV];
    set_vec[`SVS_ST_FB_OV+2:`SVS_ST_FB_OV] =
      ch_deg[`SVS_CH_FB_OV+2:`SVS_CH_FB_OV];
    set_vec[`SVS_ST_FB_UV+2:`SVS_ST_FB_UV] =
      ch_deg[`SVS_CH_FB_UV+2:`SVS_CH_FB_UV];
    set_vec[`SVS_ST_FB_STG+2:`SVS_ST_FB_STG] = fb_stg;
    set_vec[`SVS_ST_EXT_OV+1:`SVS_ST_EXT_OV] = ext_ov_evt;
    set_vec[`SVS_ST_EXT_UV+1:`SVS_ST_EXT_UV] =
      ch_deg[`SVS_CH_EXT_UV+1:`SVS_CH_EXT_UV];
    set_vec[`SVS_ST_EXT_STG+1:`SVS_ST_EXT_STG] = ext_stg;
    set_vec[`SVS_ST_WARN_A] = warn_evt && !cause_s;
    set_vec[`SVS_ST_WARN_B] = warn_evt && cause_s;
    set_vec[`SVS_ST_FLT_A]  = flt_evt && !cause_s;
    set_vec[`SVS_ST_FLT_B]  = flt_evt && cause_s;
  end

  // wishbone decode
  wire        req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wr     = req && wb_we_i;
  wire [31:0] wmask  = lane_mask(wb_sel_i);
  wire [31:0] wbits  = wb_dat_i & wmask;
  wire        hit_st = (wb_adr_i == `SVS_ADR_STATUS);
  wire        hit_mk = (wb_adr_i == `SVS_ADR_MASK);
  wire        hit_ct = (wb_adr_i == `SVS_ADR_CTRL);
  wire        hit_lv = (wb_adr_i == `SVS_ADR_LIVE);

  reg  [NST-1:0] status_reg;
  reg  [NST-1:0] mask_reg;
  reg  [1:0]     ctrl_reg;
  reg  [1:0]     trip_reg;
  wire [NST-1:0] clr_vec = (wr && hit_st) ? wbits[NST-1:0] : {NST{1'b0}};
  wire [NST-1:0] status_next = (status_reg & ~clr_vec) | set_vec;
  wire [NST-1:0] mask_next =
    (mask_reg & ~wmask[NST-1:0]) | wbits[NST-1:0];
  wire [1:0]     ctrl_next = (ctrl_reg & ~wmask[1:0]) | wbits[1:0];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      status_reg <= `SVS_STAT_RST;
      mask_reg   <= `SVS_MASK_RST;
      ctrl_reg   <= `SVS_CTRL_RST;
    end else begin
      status_reg <= status_next;
      if (wr && hit_mk) begin
        mask_reg <= mask_next;
      end
      if (wr && hit_ct) begin
        ctrl_reg <= ctrl_next;
      end
    end
  end

  // trip stays until software withdraws the enable request
  wire [1:0] trip_set = ext_ov_evt | ext_stg;
  wire [1:0] ctrl_now = (wr && hit_ct) ? ctrl_next : ctrl_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      trip_reg <= 2'h0;
    end else begin
      trip_reg <= (trip_reg & ctrl_now) | trip_set;
    end
  end

  // live view for the live register
  wire [31:0] live_word = {12'h000, fault_req, hard_reset, !reset_out_n,
                           ext_en_reg, ch_qual};

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        case (1'b1)
          hit_st:  wb_dat_o <= {{(32-NST){1'b0}}, status_reg};
          hit_mk:  wb_dat_o <= {{(32-NST){1'b0}}, mask_reg};
          hit_ct:  wb_dat_o <= {30'h00000000, ctrl_reg};
          hit_lv:  wb_dat_o <= live_word;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // supervisor actions
  wire io_bad = ch_qual[`SVS_CH_IO_OV] || ch_qual[`SVS_CH_IO_UV];
  reg  io_stg_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      io_stg_reg <= 1'b0;
    end else if (ch_stg[`SVS_CH_IO_UV]) begin
      io_stg_reg <= 1'b1;
    end else if (!ch_qual[`SVS_CH_IO_UV]) begin
      io_stg_reg <= 1'b0;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reset_out_n   <= 1'b0;
      hard_reset    <= 1'b0;
      fault_req     <= 1'b0;
      ext_en_reg    <= 2'h0;
      ext_rail_a_en <= 1'b0;
      ext_rail_b_en <= 1'b0;
      irq           <= 1'b0;
    end else begin
      reset_out_n <= !(io_bad || set_vec[`SVS_ST_IO_OV] ||
                       set_vec[`SVS_ST_IO_UV]);
      hard_reset <= io_stg_reg || ch_stg[`SVS_CH_IO_UV];
      if (flt_evt) begin
        fault_req <= 1'b1;
      end
      // enable drops on trip or fault
      ext_en_reg    <= ctrl_now & ~trip_reg & ~trip_set &
                       {2{!(fault_req || flt_evt)}};
      ext_rail_a_en <= ctrl_now[0] && !trip_reg[0] && !trip_set[0] &&
                       !(fault_req || flt_evt);
      ext_rail_b_en <= ctrl_now[1] && !trip_reg[1] && !trip_set[1] &&
                       !(fault_req || flt_evt);
      irq <= |(status_next & mask_reg);
    end
  end

endmodule // svs_top

/* File: bench/svs_top_props.sv */
// port-level assertions for the supply voltage supervisor
`timescale 1ns/100ps
module svs_chk (
  input wire       clk,           // system clock
  input wire       reset,         // async reset, active high
  input wire       io_ov_cmp,     // io supply over
  input wire       io_uv_cmp,     // io supply under
  input wire [1:0] ext_ov_cmp,    // external rail over
  input wire       ref_warn_cmp,  // reference warning
  input wire       reset_out_n,   // reset output, active low
  input wire       hard_reset,    // hard reset request
  input wire       fault_req,     // fault state request
  input wire       ext_rail_a_en, // external rail a enable
  input wire       ext_rail_b_en, // external rail b enable
  input wire       irq            // interrupt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  io_rst_low_a: assert property (io_uv_cmp [*5] |-> ##[0:4] !reset_out_n)
    else $error("reset output not low on io undervoltage");
  io_rst_rel_a: assert property ((!io_ov_cmp && !io_uv_cmp) [*8] |-> reset_out_n)
    else $error("reset output held low without io event");
  rst_deglitch_a: assert property ($fell(reset_out_n) |->
    $past(io_ov_cmp || io_uv_cmp, 3) && $past(io_ov_cmp || io_uv_cmp, 4)
    && $past(io_ov_cmp || io_uv_cmp, 5))
    else $error("reset output fell before deglitch time");
  stg_hard_a: assert property ($rose(hard_reset) |->
    $past(io_uv_cmp, 20) && $past(io_uv_cmp, 3))
    else $error("hard reset without long io undervoltage");
  ext_trip_a: assert property ((ext_rail_a_en && ext_ov_cmp[0]) [*5]
    |-> ##[0:4] !ext_rail_a_en)
    else $error("rail a not shut down on overvoltage");
  warn_irq_a: assert property ($rose(ref_warn_cmp) |-> ##[1:6] irq)
    else $error("no interrupt on reference warning");
  fault_hold_a: assert property (fault_req |=> fault_req)
    else $error("fault request dropped before reset");
  fault_off_a: assert property (fault_req |=> !ext_rail_a_en && !ext_rail_b_en)
    else $error("rail enabled while in fault");
endmodule // svs_chk

bind svs_top svs_chk u_chk (.clk(clk), .reset(reset), .io_ov_cmp(io_ov_cmp),
  .io_uv_cmp(io_uv_cmp), .ext_ov_cmp(ext_ov_cmp), .ref_warn_cmp(ref_warn_cmp),
  .reset_out_n(reset_out_n), .hard_reset(hard_reset), .fault_req(fault_req),
  .ext_rail_a_en(ext_rail_a_en), .ext_rail_b_en(ext_rail_b_en), .irq(irq));

/* File: bench/svs_supply_model.sv */
// io supply window comparator model: level in mV to comparator outputs
`timescale 1ns/100ps
module svs_supply_model #(
  parameter UV_MV = 16'h0AF0, // undervoltage threshold, 2800 mV
  parameter OV_MV = 16'h1612  // overvoltage threshold, 5650 mV
) (
  input  wire [15:0] io_mv,     // host_io_supply level in mV
  output wire        io_ov_cmp, // above overvoltage threshold
  output wire        io_uv_cmp  // below undervoltage threshold
);
  // no hysteresis: the bench steps the level well past each threshold
  assign io_ov_cmp = (io_mv > OV_MV);
  assign io_uv_cmp = (io_mv < UV_MV);
endmodule // svs_supply_model

/* File: bench/svs_top_tb_top.sv */
// self-checking bench for the supply voltage supervisor
`timescale 1ns/100ps
`include "svs_consts.vh"
module svs_top_tb_top;
  localparam DEG = 4;
  localparam IOS = 40;
  localparam RS  = 30;
  reg         clk = 1'h0, reset = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wdat = 32'h0, q;
  reg  [15:0] io_mv = 16'h0CE4;
  reg         bat = 1'h0, rwarn = 1'h0, rfault = 1'h0, rcause = 1'h0;
  reg  [2:0]  fb_ov = 3'h0, fb_uv = 3'h0, fb_duv = 3'h0, rail_on = 3'h0;
  reg  [1:0]  ext_ov = 2'h0, ext_uv = 2'h0;
  wire [31:0] rdat;
  wire        ack, io_ov, io_uv, rst_n, hrst, freq, ena, enb, irq;
  integer     mismatches = 0, num_checks = 0;

  always #5 clk = ~clk;

  svs_supply_model u_sup (.io_mv(io_mv), .io_ov_cmp(io_ov), .io_uv_cmp(io_uv));
  svs_top #(.IO_STG_CYC(IOS), .RAIL_STG_CYC(RS), .DEG_CYC(DEG)) dut (
    .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .io_ov_cmp(io_ov), .io_uv_cmp(io_uv), .bat_uv_cmp(bat),
    .fb_ov_cmp(fb_ov), .fb_uv_cmp(fb_uv), .fb_duv_cmp(fb_duv[1:0]),
    .ext_ov_cmp(ext_ov), .ext_uv_cmp(ext_uv), .ref_warn_cmp(rwarn),
    .ref_fault_cmp(rfault), .ref_cause_b(rcause), .rail_on(rail_on),
    .reset_out_n(rst_n), .hard_reset(hrst), .fault_req(freq),
    .ext_rail_a_en(ena), .ext_rail_b_en(enb), .irq(irq));

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // request held until ack is sampled, then released for one cycle
  task bus(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      @(posedge clk);
      while (ack !== 1'h1 && n < 50) begin
        n = n + 1;
        @(posedge clk);
      end
      q = rdat;
      if (n >= 50) chk(32'h0, 32'h1);
      cyc <= 1'h0;
      stb <= 1'h0;
    end
  endtask

  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(1'h0, a, 32'h0);
      chk(q, e);
    end
  endtask

  task t_regs;
    begin
      rd(`SVS_ADR_MASK, `SVS_MASK_RST);
      rd(`SVS_ADR_STATUS, 32'h0);
      rd(`SVS_ADR_LIVE, 32'h0);
      bus(1'h1, 8'h10, 32'hFFFFFFFF);
      rd(8'h10, 32'h0);
      bus(1'h1, `SVS_ADR_LIVE, 32'hFFFFFFFF);
      rd(`SVS_ADR_LIVE, 32'h0);
      bus(1'h1, `SVS_ADR_CTRL, 32'hFFFFFFFF);
      rd(`SVS_ADR_CTRL, 32'h3);
      chk({ena, enb}, 32'h3);
      bus(1'h1, `SVS_ADR_CTRL, 32'h0);
    end
  endtask

  task t_io;
    begin
      io_mv <= 16'h07D0;
      repeat (DEG - 1) @(posedge clk);
      io_mv <= 16'h0CE4;
      repeat (2) @(posedge clk);
      io_mv <= 16'h07D0;
      repeat (DEG - 1) @(posedge clk);
      io_mv <= 16'h0CE4;
      repeat (10) @(posedge clk);
      chk(rst_n, 32'h1);
      rd(`SVS_ADR_STATUS, 32'h0);
      io_mv <= 16'h07D0;
      repeat (DEG + 6) @(posedge clk);
      chk(rst_n, 32'h0);
      rd(`SVS_ADR_STATUS, 32'h2);
      repeat (IOS) @(posedge clk);
      chk(hrst, 32'h1);
      rd(`SVS_ADR_STATUS, 32'h6);
      io_mv <= 16'h0CE4;
      repeat (8) @(posedge clk);
      chk({rst_n, hrst}, 32'h2);
      rd(`SVS_ADR_STATUS, 32'h6);
      io_mv <= 16'h1770;
      repeat (DEG + 6) @(posedge clk);
      chk(rst_n, 32'h0);
      io_mv <= 16'h0CE4;
      bus(1'h1, `SVS_ADR_STATUS, 32'h7);
      rd(`SVS_ADR_STATUS, 32'h0);
    end
  endtask

  task t_bat;
    begin
      bus(1'h1, `SVS_ADR_MASK, `SVS_MASK_RST | 32'h8);
      bat <= 1'h1;
      repeat (DEG + 6) @(posedge clk);
      bat <= 1'h0;
      repeat (4) @(posedge clk);
      chk(irq, 32'h1);
      rd(`SVS_ADR_STATUS, 32'h8);
      bus(1'h1, `SVS_ADR_MASK, `SVS_MASK_RST);
      repeat (2) @(posedge clk);
      chk(irq, 32'h0);
      bus(1'h1, `SVS_ADR_MASK, `SVS_MASK_RST | 32'h8);
      repeat (2) @(posedge clk);
      chk(irq, 32'h1);
      bus(1'h1, `SVS_ADR_STATUS, 32'h8);
      repeat (2) @(posedge clk);
      chk(irq, 32'h0);
    end
  endtask

  task t_rails;
    begin
      fb_uv <= 3'h1;
      repeat (RS + 10) @(posedge clk);
      rd(`SVS_ADR_STATUS, 32'h0);
      rail_on <= 3'h7;
      fb_duv <= 3'h2;
      fb_ov <= 3'h4;
      repeat (DEG + 8) @(posedge clk);
      rd(`SVS_ADR_STATUS, 32'h8C0);
      repeat (RS) @(posedge clk);
      rd(`SVS_ADR_STATUS, 32'hCC0);
      fb_uv <= 3'h0;
      fb_duv <= 3'h0;
      fb_ov <= 3'h0;
      rail_on <= 3'h0;
      bus(1'h1, `SVS_ADR_STATUS, 32'h7FFFFF);
    end
  endtask

  task t_ext;
    begin
      bus(1'h1, `SVS_ADR_CTRL, 32'h3);
      repeat (2) @(posedge clk);
      chk({ena, enb}, 32'h3);
      ext_ov <= 2'h1;
      ext_uv <= 2'h2;
      repeat (DEG + 8) @(posedge clk);
      chk({ena, enb}, 32'h1);
      repeat (RS) @(posedge clk);
      chk(enb, 32'h0);
      rd(`SVS_ADR_STATUS, 32'h52000);
      ext_ov <= 2'h0;
      ext_uv <= 2'h0;
      bus(1'h1, `SVS_ADR_CTRL, 32'h0);
      bus(1'h1, `SVS_ADR_STATUS, 32'h7FFFFF);
    end
  endtask

  task t_ref;
    begin
      rcause <= 1'h1;
      rwarn <= 1'h1;
      repeat (6) @(posedge clk);
      chk(irq, 32'h1);
      rd(`SVS_ADR_STATUS, 32'h100000);
      rwarn <= 1'h0;
      bus(1'h1, `SVS_ADR_STATUS, 32'h100000);
      bus(1'h1, `SVS_ADR_CTRL, 32'h3);
      rcause <= 1'h0;
      rfault <= 1'h1;
      repeat (6) @(posedge clk);
      chk({freq, ena, enb}, 32'h4);
      rd(`SVS_ADR_STATUS, 32'h200000);
      rfault <= 1'h0;
      repeat (4) @(posedge clk);
      chk(freq, 32'h1);
      reset <= 1'h1;
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      repeat (2) @(posedge clk);
      chk(freq, 32'h0);
      rd(`SVS_ADR_STATUS, 32'h0);
    end
  endtask

  initial begin
    #200000;
    mismatches = mismatches + 1;
    give_verdict;
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    t_regs;
    t_io;
    t_bat;
    t_rails;
    t_ext;
    t_ref;
    give_verdict;
  end
endmodule // svs_top_tb_top
